/* File: logic/rmul_core.sv */
// Registered 12x12 multiplier with 16-bit three-state result
`timescale 1ns/1ps
// Summary of operation
// - Capture 12-bit A on A-clock rising edge, B on B-clock rising edge.
// - Register format select with B, on the same B-clock edge.
// - Format select high: both operands signed; low: both unsigned.
// - Signed mode: shift top 17 product bits left one, drop sign copy.
// - Keep 16 product MSBs, load output register on B-clock rising edge.
// - Output enable low drives product bits 23..8 (22..7 when signed), else high impedance.
module rmul_core
    import rmul_pkg::*;
#(
    parameter int AW = OPER_W
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkOperA,
    input wire logic clkOperB,
    input wire logic [AW-1:0] operandA,
    input wire logic [AW-1:0] operandB,
    input wire logic operand_format_select,
    input wire logic outEnable_n,
    output logic [RES_W-1:0] result_bus_o,
    output logic [RES_W-1:0] result_bus_oe_n
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    // Pins come from outside clk_sys; device clocks are sampled as levels
    // Enable enters inverted: the zero reset of the sync reads as disabled,
    // so the bus is never driven in the cycles just after reset
    localparam int SW = 2 * AW + 4;
    logic [SW-1:0] pinSync;

    rmul_sync #(.W(SW)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din({clkOperA, clkOperB, operand_format_select, ~outEnable_n,
              operandA, operandB}),
        .dout(pinSync)
    );

    wire logic clkASync = pinSync[SW-1];
    wire logic clkBSync = pinSync[SW-2];
    wire logic fmtSync = pinSync[SW-3];
    wire logic oeSync_n = ~pinSync[SW-4];
    wire logic [AW-1:0] aSync = pinSync[2*AW-1:AW];
    wire logic [AW-1:0] bSync = pinSync[AW-1:0];

    // ****************************************
    // Edge detection
    // ****************************************
    logic clkAPrev_ff;
    logic clkBPrev_ff;
    wire logic riseA = clkASync & ~clkAPrev_ff;
    wire logic riseB = clkBSync & ~clkBPrev_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clkAPrev_ff <= 1'b0;
            clkBPrev_ff <= 1'b0;
        end else begin
            clkAPrev_ff <= clkASync;
            clkBPrev_ff <= clkBSync;
        end
    end

    // ****************************************
    // Input registers
    // ****************************************
    logic [AW-1:0] operA_ff;
    logic [AW-1:0] operB_ff;
    logic fmtSel_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            operA_ff <= OPER_RST;
        end else if (riseA) begin
            operA_ff <= aSync;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            operB_ff <= OPER_RST;
            fmtSel_ff <= FMT_UNSIGNED;
        end else if (riseB) begin
            operB_ff <= bSync;
            fmtSel_ff <= fmtSync;
        end
    end

    // ****************************************
    // Multiplier array
    // ****************************************
    // Single format bit extends both operands alike; mixing is impossible
    function automatic logic [2*AW+1:0] mulExt(
        input logic [AW-1:0] a,
        input logic [AW-1:0] b,
        input logic sgn
    );
        logic signed [AW:0] ea;
        logic signed [AW:0] eb;
        logic signed [2*AW+1:0] p;
        ea = $signed({sgn & a[AW-1], a});
        eb = $signed({sgn & b[AW-1], b});
        p = ea * eb;
        return p;
    endfunction

    wire logic [2*AW+1:0] prodFull = mulExt(operA_ff, operB_ff,
                                            fmtSel_ff);
    wire logic [PROD_W-1:0] prod = prodFull[PROD_W-1:0];
    // Left shift by one equals taking bits 22..7
    wire logic [RES_W-1:0] resSigned = prod[SGN_MSB:SGN_LSB];
    wire logic [RES_W-1:0] resUnsigned = prod[RES_MSB:RES_LSB];
    wire logic [RES_W-1:0] nxt_result =
        (fmtSel_ff == FMT_SIGNED) ? resSigned : resUnsigned;

    // ****************************************
    // Output register and drivers
    // ****************************************
    // Product sampled on the same B edge that loads new B: the register
    // takes the product of the previously held operands, as in a pipeline
    logic [RES_W-1:0] resultReg_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            resultReg_ff <= RES_RST;
        end else if (riseB) begin
            resultReg_ff <= nxt_result;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            result_bus_o <= RES_RST;
            result_bus_oe_n <= OE_ALL_OFF;
        end else begin
            result_bus_o <= (riseB) ? nxt_result : resultReg_ff;
            result_bus_oe_n <= oeSync_n ? OE_ALL_OFF : OE_ALL_ON;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Reference products built apart from the multiplier array
    wire logic signed [PROD_W-1:0] chkProdS =
        $signed(operA_ff) * $signed(operB_ff);
    wire logic [PROD_W-1:0] chkProdU =
        PROD_W'(operA_ff) * PROD_W'(operB_ff);

    sequence s_riseB;
        riseB;
    endsequence

    property p_capA;
        @(posedge clk_sys) disable iff (!arst_n)
        riseA |=> operA_ff == $past(aSync);
    endproperty
    a_capA: assert property (p_capA)
        else $error("A operand not captured on A edge");

    property p_holdB;
        @(posedge clk_sys) disable iff (!arst_n)
        !riseB |=> $stable(operB_ff) && $stable(fmtSel_ff);
    endproperty
    a_holdB: assert property (p_holdB)
        else $error("B operand or format changed without B edge");

    property p_fmtB;
        @(posedge clk_sys) disable iff (!arst_n)
        s_riseB |=> fmtSel_ff == $past(fmtSync) &&
                    operB_ff == $past(bSync);
    endproperty
    a_fmtB: assert property (p_fmtB)
        else $error("Format not captured with B operand");

    property p_signedVal;
        @(posedge clk_sys) disable iff (!arst_n)
        fmtSel_ff |-> $signed(prod) ==
            $signed(operA_ff) * $signed(operB_ff);
    endproperty
    a_signedVal: assert property (p_signedVal)
        else $error("Signed product wrong");

    property p_shift;
        @(posedge clk_sys) disable iff (!arst_n)
        s_riseB ##0 fmtSel_ff |=>
            resultReg_ff == $past(chkProdS[SGN_MSB:SGN_LSB]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("Signed result not shifted left by one");

    property p_unsigned;
        @(posedge clk_sys) disable iff (!arst_n)
        s_riseB ##0 !fmtSel_ff |=>
            resultReg_ff == $past(chkProdU[RES_MSB:RES_LSB]);
    endproperty
    a_unsigned: assert property (p_unsigned)
        else $error("Unsigned result not product bits 23..8");

    property p_outHold;
        @(posedge clk_sys) disable iff (!arst_n)
        !riseB ##1 !riseB |-> $stable(resultReg_ff);
    endproperty
    a_outHold: assert property (p_outHold)
        else $error("Output register changed without B edge");

    property p_oe;
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(oeSync_n) |=> result_bus_oe_n == OE_ALL_ON
            ##1 result_bus_o == resultReg_ff || $past(riseB) || riseB;
    endproperty
    a_oe: assert property (p_oe)
        else $error("Output enable low did not drive result");

    property p_oeOff;
        @(posedge clk_sys) disable iff (!arst_n)
        oeSync_n |=> result_bus_oe_n == OE_ALL_OFF;
    endproperty
    a_oeOff: assert property (p_oeOff)
        else $error("Result driven while output enable high");
endmodule

/* File: common/rmul_pkg.sv */
// Constants for the registered 12x12 multiplier
package rmul_pkg;
    localparam int OPER_W = 12;
    localparam int PROD_W = 24;
    localparam int RES_W = 16;
    localparam int RES_LSB = 8;
    localparam int RES_MSB = 23;
    localparam int SGN_LSB = 7;
    localparam int SGN_MSB = 22;
    localparam logic FMT_SIGNED = 1'b1;
    localparam logic FMT_UNSIGNED = 1'b0;
    localparam logic [OPER_W-1:0] OPER_RST = 12'h000;
    localparam logic [RES_W-1:0] RES_RST = 16'h0000;
    localparam logic [RES_W-1:0] OE_ALL_OFF = 16'hFFFF;
    localparam logic [RES_W-1:0] OE_ALL_ON = 16'h0000;
endpackage

/* File: logic/rmul_sync.sv */
// Two-flop synchroniser for a bus of level signals
`timescale 1ns/1ps
module rmul_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1_ff <= '0;
            dout <= '0;
        end else begin
            stage1_ff <= din;
            dout <= stage1_ff;
        end
    end
endmodule

/* File: dv/rmul_host_model.sv */
// Host pin driver and three-state result bus model
`timescale 1ns/1ps
module rmul_host_model
    import rmul_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [RES_W-1:0] busVal,
    input wire logic [RES_W-1:0] busOe_n,
    output logic clkOperA,
    output logic clkOperB,
    output logic [OPER_W-1:0] operandA,
    output logic [OPER_W-1:0] operandB,
    output logic fmtSel,
    output logic [RES_W-1:0] busWire
);
    logic [RES_W-1:0] lastVal;
    // Released bits toggle each cycle so a stale value never passes
    assign busWire = (busVal & ~busOe_n) | (~lastVal & busOe_n);
    initial begin
        lastVal = 16'h0000;
        clkOperA = 1'b0;
        clkOperB = 1'b0;
        operandA = 12'h000;
        operandB = 12'h000;
        fmtSel = FMT_UNSIGNED;
    end
    always @(posedge clk_sys) begin
        lastVal <= busWire;
    end
    // Pins held 4 cycles around each edge to clear the synchroniser
    task automatic hold4();
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic loadA(input logic [OPER_W-1:0] a);
        operandA = a;
        clkOperA = 1'b1;
        hold4();
        clkOperA = 1'b0;
        hold4();
    endtask
    // One format bit goes with B; both operands share it
    task automatic loadB(input logic [OPER_W-1:0] b, input logic f);
        operandB = b;
        fmtSel = f;
        clkOperB = 1'b1;
        hold4();
        clkOperB = 1'b0;
        hold4();
    endtask
endmodule

/* File: dv/registered_12x12_multiplier_tb_top.sv */
// Self-checking bench for the registered multiplier
`timescale 1ns/1ps
module registered_12x12_multiplier_tb_top
    import rmul_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic outEnable_n = 1'b1;
    logic clkOperA, clkOperB, fmtSel;
    logic [OPER_W-1:0] operandA, operandB;
    logic [RES_W-1:0] resVal, resOe_n, busWire;
    int errCount = 0;
    int checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    rmul_core dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .clkOperA(clkOperA), .clkOperB(clkOperB), .operandA(operandA),
        .operandB(operandB), .operand_format_select(fmtSel),
        .outEnable_n(outEnable_n), .result_bus_o(resVal),
        .result_bus_oe_n(resOe_n));
    rmul_host_model host (.clk_sys(clk_sys), .busVal(resVal),
        .busOe_n(resOe_n), .clkOperA(clkOperA), .clkOperB(clkOperB),
        .operandA(operandA), .operandB(operandB), .fmtSel(fmtSel),
        .busWire(busWire));
    task automatic check(input string what, input logic [RES_W-1:0] seen,
        input logic [RES_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [RES_W-1:0] expRes(input logic [OPER_W-1:0] a,
        input logic [OPER_W-1:0] b, input logic f);
        logic [PROD_W-1:0] p;
        if (f === FMT_SIGNED) begin
            p = $signed(a) * $signed(b);
            return p[SGN_MSB:SGN_LSB];
        end
        p = a * b;
        return p[RES_MSB:RES_LSB];
    endfunction
    task automatic test_reset();
        check("oe after reset", resOe_n, OE_ALL_OFF);
        check("result after reset", resVal, RES_RST);
        $display("test_reset done");
    endtask
    task automatic test_products();
        logic [OPER_W-1:0] ta [5] = '{12'hFFF, 12'h800, 12'hFFF, 12'h7FF,
            12'hABC};
        logic [OPER_W-1:0] tb [5] = '{12'hFFF, 12'h800, 12'h001, 12'h800,
            12'h123};
        logic tf [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        outEnable_n = 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.loadA(ta[i]);
            host.loadB(tb[i], tf[i]);
            host.loadB(tb[i], tf[i]);
            check("product", busWire, expRes(ta[i], tb[i], tf[i]));
            check("oe driving", resOe_n, OE_ALL_ON);
        end
        $display("test_products done");
    endtask
    // Format pin flipped and A reloaded: nothing may move until a B edge
    task automatic test_edges();
        host.loadB(12'h9A5, FMT_SIGNED);
        host.loadA(12'hC37);
        host.fmtSel = FMT_UNSIGNED;
        host.hold4();
        check("held result", busWire, expRes(12'hABC, 12'h123, 1'b0));
        host.loadA(12'h5E1);
        host.loadB(12'h123, FMT_UNSIGNED);
        check("fmt with B", busWire, expRes(12'h5E1, 12'h9A5, 1'b1));
        outEnable_n = 1'b1;
        host.hold4();
        check("oe released", resOe_n, OE_ALL_OFF);
        $display("test_edges done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        test_reset();
        test_products();
        test_edges();
        report_and_stop();
    end
    initial begin
        #(25 * 5000);
        errCount++;
        report_and_stop();
    end
endmodule
